/* logic/hsc_top.v */
// multi-channel high-speed counter with target-match output control
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defs.vh"

module hsc_top #(
    parameter NCH = 4,   // number of counter channels
    parameter CHW = 2    // channel index width
) (
    input wire mclk_in,                 // controller clock, 200 MHz
    input wire nrst_in,                 // synchronous reset, active low
    input wire [NCH-1:0] cnt_a_in,      // count input a per channel (pin)
    input wire [NCH-1:0] cnt_b_in,      // count input b per channel (pin)
    input wire [NCH-1:0] rst_pin_in,    // reset input per channel (pin)
    input wire [NCH-1:0] two_phase_in,  // per channel input mode, static
    input wire ctl_wr_in,               // counter control command strobe
    input wire [15:0] ctl_word_in,      // counter control word
    input wire ev_wr_in,                // elapsed value write strobe
    input wire ev_rd_in,                // elapsed value read strobe
    input wire [CHW-1:0] ev_ch_in,      // channel for elapsed move
    input wire [15:0] ev_lo_in,         // elapsed count low word
    input wire [15:0] ev_hi_in,         // elapsed count high word
    input wire cmp_start_in,            // match command strobe
    input wire cmp_set_in,              // 1: set-output, 0: clear-output
    input wire [CHW-1:0] cmp_ch_in,     // match command channel
    input wire [31:0] cmp_target_in,    // target value
    input wire [2:0] cmp_out_sel_in,    // which general output
    output reg [15:0] ev_lo_out,        // read elapsed low word
    output reg [15:0] ev_hi_out,        // read elapsed high word
    output reg ev_rd_valid_out,         // read data valid pulse
    output reg cmp_ack_out,             // match command accepted pulse
    output reg cmp_refused_out,         // match command refused pulse
    output reg [`HSC_NUM_OUTS-1:0] gen_out,  // general outputs
    output reg [NCH-1:0] busy_out,      // in-progress flags
    output reg [NCH-1:0] irq_out,       // pending match interrupts
    output reg [NCH*16-1:0] ctl_store_out // stored control per channel
);

    // per-channel state
    reg [31:0] cnt_q [0:NCH-1];          // elapsed values
    reg [15:0] ctl_q [0:NCH-1];          // stored control codes
    reg [31:0] tgt_q [0:NCH-1];          // armed targets
    reg [2:0] sel_q [0:NCH-1];           // output chosen by the match
    reg [NCH-1:0] pol_q;                 // level driven on match
    wire [NCH-1:0] up_w;                 // decoded up pulses
    wire [NCH-1:0] dn_w;                 // decoded down pulses
    wire [NCH-1:0] rst_lvl_w;            // synced reset inputs
    reg [NCH-1:0] fire_w;                // match this cycle
    reg [NCH-1:0] ctl_hit_w; // control write names this channel
    // each process keeps its own loop index, so no variable has two writers

    // channel-selector decode, used by the control path only
    function sel_hit;
        input [3:0] sel;
        input integer ch;
        begin
            sel_hit = (sel == ch[3:0]);
        end
    endfunction

    // channel-index compare, shared by the move and match paths
    // the index is cut to CHW bits; callers pass 0..NCH-1 only
    function ch_hit;
        input [CHW-1:0] sel;
        input integer ch;
        begin
            ch_hit = (sel == ch[CHW-1:0]);
        end
    endfunction

    // input decoders, one per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : chan
            hsc_in_dec u_dec (
                .mclk_in(mclk_in),
                .nrst_in(nrst_in),
                .pin_a_in(cnt_a_in[g]),
                .pin_b_in(cnt_b_in[g]),
                .pin_rst_in(rst_pin_in[g]),
                .two_phase_in(two_phase_in[g]),
                .up_out(up_w[g]),
                .dn_out(dn_w[g]),
                .rst_lvl_out(rst_lvl_w[g])
            );
        end
    endgenerate

    // control-word channel decode, shared by store, cancel and irq clear
    always @*
    begin : ctl_dec
        integer i;
        ctl_hit_w = {NCH{1'b0}};
        for (i = 0; i < NCH; i = i + 1)
        begin
            // selectors at or above NCH hit nothing and are dropped
            ctl_hit_w[i] = ctl_wr_in &&
                sel_hit(ctl_word_in[`HSC_CTL_CH_MSB:`HSC_CTL_CH_LSB], i);
        end
    end

    // match detect on the live count
    always @*
    begin : fire_dec
        integer i;
        fire_w = {NCH{1'b0}};
        for (i = 0; i < NCH; i = i + 1)
        begin
            fire_w[i] = busy_out[i] && (cnt_q[i] == tgt_q[i]);
        end
    end

    // control store: latched per channel, held until rewritten
    always @(posedge mclk_in)
    begin : ctl_store
        integer i;
        for (i = 0; i < NCH; i = i + 1)
        begin
            if (!nrst_in)
            begin
                ctl_q[i] <= `HSC_CTL_RESET;
            end
            else if (ctl_hit_w[i])
            begin
                // only the addressed channel changes; the others keep theirs
                ctl_q[i] <= {4'h0, ctl_word_in[11:0]};
            end
        end
    end

    // stored codes readable flat
    // upper nibble of each stored word always reads zero
    always @*
    begin : ctl_flat
        integer i;
        ctl_store_out = {NCH*16{1'b0}};
        for (i = 0; i < NCH; i = i + 1)
        begin
            ctl_store_out[i*16 +: 16] = ctl_q[i];
        end
    end

    // elapsed counters
    // priority: sw reset, hw reset, move, then pulses
    always @(posedge mclk_in)
    begin : ev_count
        integer i;
        for (i = 0; i < NCH; i = i + 1)
        begin
            if (!nrst_in)
            begin
                cnt_q[i] <= `HSC_CNT_RESET;
            end
            else if (ctl_q[i][`HSC_CTL_SWRST_BIT])
            begin
                // held at zero until a rewrite clears bit0
                cnt_q[i] <= `HSC_CNT_RESET;
            end
            else if (rst_lvl_w[i] && !ctl_q[i][`HSC_CTL_HWDIS_BIT])
            begin
                // rise clears and stops; release resumes from zero
                cnt_q[i] <= `HSC_CNT_RESET;
            end
            else if (ev_wr_in && ch_hit(ev_ch_in, i))
            begin
                // a move loses to either reset, so a held zero stays zero
                cnt_q[i] <= {ev_hi_in, ev_lo_in};
            end
            else if (!ctl_q[i][`HSC_CTL_CNTDIS_BIT])
            begin
                // disabled channels drop pulses, they are not saved up
                if (up_w[i])
                begin
                    cnt_q[i] <= cnt_q[i] + 32'h0000_0001;
                end
                else if (dn_w[i])
                begin
                    cnt_q[i] <= cnt_q[i] - 32'h0000_0001;
                end
            end
        end
    end

    // elapsed read, low word and high word together
    always @(posedge mclk_in)
    begin
        if (!nrst_in)
        begin
            ev_lo_out <= 16'h0000;
            ev_hi_out <= 16'h0000;
            ev_rd_valid_out <= 1'b0;
        end
        else
        begin
            // data stands until the next read; only valid is a pulse
            ev_rd_valid_out <= ev_rd_in;
            if (ev_rd_in)
            begin
                ev_lo_out <= cnt_q[ev_ch_in][15:0];
                ev_hi_out <= cnt_q[ev_ch_in][31:16];
            end
        end
    end

    // compare arming, cancel and in-progress flags
    always @(posedge mclk_in)
    begin : arm_ctl
        integer i;
        if (!nrst_in)
        begin
            busy_out <= {NCH{1'b0}};
            pol_q <= {NCH{1'b0}};
            cmp_ack_out <= 1'b0;
            cmp_refused_out <= 1'b0;
            for (i = 0; i < NCH; i = i + 1)
            begin
                tgt_q[i] <= 32'h0000_0000;
                sel_q[i] <= 3'h0;
            end
        end
        else
        begin
            // busy decides refusal, so a cancel in the same cycle does not admit
            cmp_ack_out <= cmp_start_in && !busy_out[cmp_ch_in];
            cmp_refused_out <= cmp_start_in && busy_out[cmp_ch_in];
            for (i = 0; i < NCH; i = i + 1)
            begin
                // only an idle channel takes a new command
                if (cmp_start_in && ch_hit(cmp_ch_in, i) && !busy_out[i])
                begin
                    // target and output are captured once, at acceptance
                    busy_out[i] <= 1'b1;
                    tgt_q[i] <= cmp_target_in;
                    sel_q[i] <= cmp_out_sel_in;
                    pol_q[i] <= cmp_set_in;
                end
                else if (fire_w[i])
                begin
                    // a match frees the channel
                    busy_out[i] <= 1'b0;
                end
                else if (ctl_hit_w[i] && ctl_word_in[`HSC_CTL_CANCEL_BIT])
                begin
                    // cancel is taken even while busy, it is never refused
                    busy_out[i] <= 1'b0;
                end
            end
        end
    end

    // general outputs; higher channel wins if two hit the same output at once
    always @(posedge mclk_in)
    begin : gen_drive
        integer i;
        // outputs start low and move only on a match
        if (!nrst_in)
        begin
            gen_out <= {`HSC_NUM_OUTS{1'b0}};
        end
        else
        begin
            for (i = 0; i < NCH; i = i + 1)
            begin
                if (fire_w[i])
                begin
                    gen_out[sel_q[i]] <= pol_q[i];
                end
            end
        end
    end

    // match interrupts; a new match beats a clear in the same cycle
    always @(posedge mclk_in)
    begin : irq_flag
        integer i;
        // pending flags start clear after reset
        if (!nrst_in)
        begin
            irq_out <= {NCH{1'b0}};
        end
        else
        begin
            for (i = 0; i < NCH; i = i + 1)
            begin
                if (fire_w[i])
                begin
                    irq_out[i] <= 1'b1;
                end
                else if (ctl_hit_w[i] && ctl_word_in[`HSC_CTL_IRQCLR_BIT])
                begin
                    // clear only when no match lands in the same cycle
                    irq_out[i] <= 1'b0;
                end
            end
        end
    end

endmodule

`default_nettype wire

/* logic/hsc_defs.vh */
// constants for the multi-channel high-speed counter with target match
// Overview of operation
// - count input pulses, drive chosen output on match
// - set command drives high, clear drives low
// - matched output chosen from eight general outputs
// - reset input rising: stop and clear count
// - reset input falling: resume from cleared value
// - control bit0 clears and holds count zero
// - counting resumes only after rewrite clearing bit0
// - control bit1 disables counting of input pulses
// - control bit2 makes reset input ignored
// - control settings persist until rewritten for channel
// - top hex digit of control selects channel
// - each channel stores its own control code
// - 32-bit elapsed value, low word first
// - software reads and overwrites elapsed value
// - control command cancels armed compare, frees channel
// - control command clears pending match interrupt
// - in-progress flag set while compare armed
// - new compare refused while channel in progress
`ifndef HSC_DEFS_VH
`define HSC_DEFS_VH

// control word field layout
`define HSC_CTL_SWRST_BIT 0
`define HSC_CTL_CNTDIS_BIT 1
`define HSC_CTL_HWDIS_BIT 2
`define HSC_CTL_CANCEL_BIT 3
`define HSC_CTL_IRQCLR_BIT 4
`define HSC_CTL_CH_MSB 15
`define HSC_CTL_CH_LSB 12

// reset values
`define HSC_CTL_RESET 16'h0000
`define HSC_CNT_RESET 32'h0000_0000

// general outputs reachable by a match
`define HSC_NUM_OUTS 8
`define HSC_OUT_SEL_W 3

`endif

/* logic/hsc_in_dec.v */
// input synchroniser and pulse decoder for one counter channel
`timescale 1ns/1ps
`default_nettype none

module hsc_in_dec (
    input wire mclk_in,          // controller clock
    input wire nrst_in,          // synchronous reset, active low
    input wire pin_a_in,         // count input a (pin)
    input wire pin_b_in,         // count input b (pin)
    input wire pin_rst_in,       // channel reset input (pin)
    input wire two_phase_in,     // 1: two-phase decode, 0: single-phase
    output reg up_out,           // one-cycle count-up pulse
    output reg dn_out,           // one-cycle count-down pulse
    output wire rst_lvl_out      // synchronised reset input level
);

    // two-flop synchronisers; stage 1 is read by stage 2 only
    reg [2:0] s1_q;
    reg [2:0] s2_q;
    reg [1:0] prev_q; // previous synced a/b for edge detect
    wire a_now;
    wire b_now;
    wire a_chg;
    wire b_chg;

    assign a_now = s2_q[0];
    assign b_now = s2_q[1];
    assign a_chg = a_now ^ prev_q[0];
    assign b_chg = b_now ^ prev_q[1];
    assign rst_lvl_out = s2_q[2];

    // synchroniser and history
    always @(posedge mclk_in)
    begin
        if (!nrst_in)
        begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            prev_q <= 2'h0;
        end
        else
        begin
            s1_q <= {pin_rst_in, pin_b_in, pin_a_in};
            s2_q <= s1_q;
            prev_q <= {b_now, a_now};
        end
    end

    // pulse decode, registered
    always @(posedge mclk_in)
    begin
        if (!nrst_in)
        begin
            up_out <= 1'b0;
            dn_out <= 1'b0;
        end
        else if (two_phase_in)
        begin
            // one-phase-at-a-time change only; a double jump is a glitch, drop it
            up_out <= (a_chg ^ b_chg) & (a_now ^ prev_q[1]);
            dn_out <= (a_chg ^ b_chg) & ~(a_now ^ prev_q[1]);
        end
        else
        begin
            // single-phase: rising edge of a counts up
            up_out <= a_now & ~prev_q[0];
            dn_out <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* test/hsc_enc_model.sv */
// encoder pulse source feeding the counter inputs
`timescale 1ns/1ps
`default_nettype none
module hsc_enc_model (
    input wire logic clk_in,        // bench clock
    input wire logic go_in,         // request one full encoder cycle
    input wire logic up_in,         // 1: a leads b
    input wire logic [3:0] hold_in, // cycles per phase step, prompt or slow
    output logic a_out,             // phase a
    output logic b_out,             // phase b
    output logic done_out           // one-cycle completion
);
    logic [1:0] st; // gray step index
    int i;
    initial {a_out, b_out, done_out, st} = 5'h00;
    // walk four gray steps, each held long enough for the input synchronisers
    always @(posedge clk_in)
    begin
        if (go_in && !done_out)
        begin
            for (i = 0; i < 4; i++)
            begin
                st = up_in ? st + 2'h1 : st - 2'h1;
                {a_out, b_out} <= {st[1] ^ st[0], st[1]};
                repeat (hold_in) @(posedge clk_in);
            end
            done_out <= 1'b1;
        end
        else
            done_out <= 1'b0;
    end
endmodule
`default_nettype wire

/* test/hsc_top_props.sv */
// assertion checker for the counter top ports
`timescale 1ns/1ps
`default_nettype none
module hsc_top_props #(parameter NCH = 4, parameter CHW = 2) (
    input wire logic mclk_in,               // clock
    input wire logic nrst_in,               // sync reset, low
    input wire logic ctl_wr_in,             // control strobe
    input wire logic [15:0] ctl_word_in,    // control word
    input wire logic ev_rd_in,              // read strobe
    input wire logic cmp_start_in,          // match strobe
    input wire logic [CHW-1:0] cmp_ch_in,   // match channel
    input wire logic ev_rd_valid_out,       // read valid
    input wire logic cmp_ack_out,           // accepted
    input wire logic cmp_refused_out,       // refused
    input wire logic [7:0] gen_out,         // general outputs
    input wire logic [NCH-1:0] busy_out,    // in progress
    input wire logic [NCH-1:0] irq_out,     // match irq
    input wire logic [NCH*16-1:0] ctl_store_out // stored control
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    a_read_valid: assert property (ev_rd_in |=> ev_rd_valid_out)
        else $error("read valid missing");
    a_valid_from_read: assert property (ev_rd_valid_out |-> $past(ev_rd_in))
        else $error("read valid without read");
    a_one_answer: assert property (cmp_start_in |=> cmp_ack_out != cmp_refused_out)
        else $error("match command answer wrong");
    a_busy_refused: assert property (cmp_start_in && busy_out[cmp_ch_in] |=> cmp_refused_out)
        else $error("busy channel not refused");
    a_ack_sets_busy: assert property (cmp_start_in && !busy_out[cmp_ch_in]
        |=> cmp_ack_out && busy_out[$past(cmp_ch_in)]) else $error("accept without busy");
    a_done_raises_irq: assert property (!$past(ctl_wr_in) && !$past(ctl_wr_in, 2)
        |-> ($past(busy_out) & ~busy_out & ~irq_out) == '0) else $error("match without irq");
    a_gen_on_match: assert property ($changed(gen_out)
        |-> ($past(busy_out) & ~busy_out) != '0) else $error("output moved without match");
    a_store_write: assert property (ctl_wr_in && ctl_word_in[15:12] == 4'h0
        |=> ctl_store_out[15:0] == {4'h0, $past(ctl_word_in[11:0])}) else $error("store bad");
    a_store_hold: assert property (!ctl_wr_in |=> $stable(ctl_store_out))
        else $error("store changed without write");
    c_accept: cover property (cmp_ack_out);
    c_refuse: cover property (cmp_refused_out);
    c_match: cover property ($rose(|irq_out));
endmodule
bind hsc_top hsc_top_props #(.NCH(NCH), .CHW(CHW)) u_props (.mclk_in, .nrst_in, .ctl_wr_in,
    .ctl_word_in, .ev_rd_in, .cmp_start_in, .cmp_ch_in, .ev_rd_valid_out, .cmp_ack_out,
    .cmp_refused_out, .gen_out, .busy_out, .irq_out, .ctl_store_out);
`default_nettype wire

/* test/hsc_top_tb.sv */
// self-checking bench for the counter top
`timescale 1ns/1ps
`default_nettype none
module hsc_top_tb;
    logic mclk_in = 0, nrst_in = 0, ctl_wr_in = 0, ev_wr_in = 0, ev_rd_in = 0;
    logic cmp_start_in = 0, cmp_set_in = 0, go = 0, up = 1, a, b, done;
    logic [3:0] rst_pin_in = 0, hold = 4'h3, cnt_a_in, cnt_b_in, two_phase_in;
    logic [15:0] ctl_word_in = 0, ev_lo_in = 0, ev_hi_in = 0, ev_lo_out, ev_hi_out;
    logic [1:0] ev_ch_in = 0, cmp_ch_in = 0;
    logic [31:0] cmp_target_in = 0, v, ex [4];
    logic [2:0] cmp_out_sel_in = 0;
    logic ev_rd_valid_out, cmp_ack_out, cmp_refused_out;
    logic [7:0] gen_out;
    logic [3:0] busy_out, irq_out, dis = 0, sw = 0, hwd = 0;
    logic [63:0] ctl_store_out;
    logic [15:0] rnd = 16'h4D4F; // lfsr seed
    int fail_count = 0, n_checks = 0, i;
    assign cnt_a_in = {4{a}};
    assign cnt_b_in = {4{b}};
    assign two_phase_in = 4'h5; // even channels quadrature, odd single-phase
    hsc_enc_model enc (.clk_in(mclk_in), .go_in(go), .up_in(up), .hold_in(hold), .a_out(a),
        .b_out(b), .done_out(done));
    hsc_top #(.NCH(4), .CHW(2)) dut (.mclk_in, .nrst_in, .cnt_a_in, .cnt_b_in, .rst_pin_in,
        .two_phase_in, .ctl_wr_in, .ctl_word_in, .ev_wr_in, .ev_rd_in, .ev_ch_in, .ev_lo_in,
        .ev_hi_in, .cmp_start_in, .cmp_set_in, .cmp_ch_in, .cmp_target_in, .cmp_out_sel_in,
        .ev_lo_out, .ev_hi_out, .ev_rd_valid_out, .cmp_ack_out, .cmp_refused_out, .gen_out,
        .busy_out, .irq_out, .ctl_store_out);
    initial forever #2.5 mclk_in = ~mclk_in;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected count after one encoder cycle: x4 quadrature or one rising edge
    function automatic logic [31:0] step(input logic [31:0] c, input logic q, input logic u);
        return q ? (u ? c + 32'h4 : c - 32'h4) : c + 32'h1;
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task tk(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task ctl(input logic [15:0] w);
        ctl_word_in = w;
        ctl_wr_in = 1;
        tk(1);
        ctl_wr_in = 0;
        if (w[15:12] < 4) // larger selectors are ignored
        begin
            {hwd[w[13:12]], dis[w[13:12]], sw[w[13:12]]} = w[2:0];
            if (w[0]) ex[w[13:12]] = 0;
            chk("store", {4'h0, w[11:0]}, ctl_store_out[w[13:12]*16 +: 16]);
        end
        tk(1);
    endtask
    task rd(input logic [1:0] c);
        ev_ch_in = c;
        ev_rd_in = 1;
        tk(1);
        ev_rd_in = 0;
        chk("valid", 1, ev_rd_valid_out);
        chk("count", ex[c], {ev_hi_out, ev_lo_out});
        tk(1);
    endtask
    // one encoder cycle, held until the model reports done
    task pulse(input logic u);
        int k;
        up = u;
        go = 1;
        for (k = 0; k < 200 && !done; k++) tk(1);
        if (!done)
        begin
            fail_count++;
            wrap_up;
        end
        go = 0;
        for (k = 0; k < 4; k++)
            if (rst_pin_in[k] && !hwd[k]) ex[k] = 0;
            else if (!dis[k] && !sw[k]) ex[k] = step(ex[k], !k[0], u);
        tk(6);
    endtask
    task cmp(input logic s, input logic [31:0] t, input logic [2:0] o, input logic acc);
        cmp_set_in = s;
        cmp_target_in = t;
        cmp_out_sel_in = o;
        cmp_start_in = 1;
        tk(1);
        cmp_start_in = 0;
        chk("ack", acc, cmp_ack_out);
        chk("refused", !acc, cmp_refused_out);
        tk(1);
    endtask
    initial
    begin
        for (i = 0; i < 4; i++) ex[i] = 0;
        tk(12);
        nrst_in = 1;
        for (i = 0; i < 4; i++) rd(i);
        repeat (3) pulse(1);
        pulse(0);
        hold = 4'h8;
        pulse(1);
        hold = 4'h3;
        for (i = 0; i < 4; i++) rd(i);
        ctl(16'h1002);
        ctl(16'h7001);
        ctl(16'h0001);
        pulse(1);
        rd(0);
        rd(1);
        rd(2);
        ctl(16'h0000);
        ctl(16'h1000);
        pulse(1);
        rd(0);
        ctl(16'h3004);
        rst_pin_in = 4'hC;
        tk(6);
        ex[2] = 0;
        pulse(1);
        rd(2);
        rd(3);
        rst_pin_in = 0;
        tk(6);
        pulse(1);
        rd(2);
        repeat (4)
        begin
            v = {rnd, lfsr(rnd)};
            ev_lo_in = v[15:0];
            ev_hi_in = v[31:16];
            ev_ch_in = rnd[1:0];
            ev_wr_in = 1;
            tk(1);
            ev_wr_in = 0;
            ex[rnd[1:0]] = v;
            rd(rnd[1:0]);
            rnd = lfsr(lfsr(rnd));
        end
        cmp_ch_in = 0;
        for (i = 0; i < 8; i++)
        begin
            cmp(1, ex[0] + 32'h4, i[2:0], 1);
            cmp(1, ex[0] + 32'h8, i[2:0], 0);
            chk("busy", 1, busy_out[0]);
            pulse(1);
            chk("out high", 1, gen_out[i]);
            chk("busy done", 0, busy_out[0]);
            chk("irq", 1, irq_out[0]);
            ctl(16'h0010);
            chk("irq clear", 0, irq_out[0]);
            cmp(0, ex[0] + 32'h4, i[2:0], 1);
            pulse(1);
            chk("out low", 0, gen_out[i]);
        end
        cmp_ch_in = 1;
        cmp(1, ex[1] + 32'h64, 3'h3, 1);
        ctl(16'h1008);
        chk("cancel", 0, busy_out[1]);
        wrap_up;
    end
endmodule
`default_nettype wire
